// [rtl/flash_seq_host.v]
// Host controller sequencing suspend, resume and lock-bit commands to a flash card
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_seq_host (
   input  wire        I_CLK_SYS,    // 10 MHz system clock
   input  wire        I_RESET,      // Synchronous reset, active high
   input  wire [7:0]  I_WB_ADR,     // Wishbone byte address
   input  wire [31:0] I_WB_DAT,     // Wishbone write data
   input  wire [3:0]  I_WB_SEL,     // Wishbone byte selects
   input  wire        I_WB_WE,      // Wishbone write enable
   input  wire        I_WB_CYC,     // Wishbone cycle
   input  wire        I_WB_STB,     // Wishbone strobe
   output reg  [31:0] O_WB_DAT,     // Wishbone read data
   output reg         O_WB_ACK,     // Wishbone acknowledge
   output reg  [20:0] O_FL_ADDR,    // Card word address
   output wire [15:0] O_FL_DQ,      // Card data out
   output wire        O_FL_DQ_OE,   // Card data drive enable
   input  wire [15:0] I_FL_DQ,      // Card data in
   output wire        O_FL_CE_N,    // Card chip enable
   output wire        O_FL_OE_N,    // Card output enable
   output wire        O_FL_WE_N,    // Card write enable
   output reg         O_FL_RESET_N, // Card reset
   input  wire        I_READY_BUSY_N // Card ready/busy, high when ready
);
   localparam [2:0] S_IDLE = 3'd0, S_CMD1 = 3'd1, S_CMD2 = 3'd2,
                    S_POLL = 3'd3, S_RDST = 3'd4, S_DONE = 3'd5;
   reg  [2:0]  state_r;
   reg  [3:0]  op_r;
   reg  [20:0] addr_r;
   reg         busy_r;
   reg         err_r;
   reg         susp_ok_r;
   reg         ers_susp_r;
   reg         wr_susp_r;
   reg         lock_unknown_r;
   reg  [7:0]  fsr_r;
   reg         bc_start_r;
   reg         bc_write_r;
   reg  [15:0] bc_wdata_r;
   wire [15:0] bc_rdata;
   wire        bc_done;
   wire        wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   wire        go = wb_req & I_WB_WE & (I_WB_ADR == `REG_CTRL) & I_WB_SEL[0]
                    & I_WB_DAT[`CTRL_GO_BIT] & ~busy_r;

   // First command word of each operation
   function [15:0] first_cmd;
      input [3:0] op;
      begin
         case (op)
            `OP_ERS_SUSP, `OP_WR_SUSP:     first_cmd = `CMD_SUSPEND;
            `OP_ERS_RESUME, `OP_WR_RESUME: first_cmd = `CMD_RESUME;
            `OP_SET_LOCK, `OP_CLR_LOCK:    first_cmd = `CMD_LOCK_SETUP;
            `OP_CLR_STATUS:                first_cmd = `CMD_CLR_STAT;
            `OP_READ_ARRAY:                first_cmd = `CMD_READ_ARRAY;
            default:                       first_cmd = `CMD_READ_STAT;
         endcase
      end
   endfunction

   // Operation legal in the suspend state the controller has seen
   function legal_op;
      input [3:0] op;
      input       es;
      input       ws;
      begin
         case (op)
            `OP_ERS_RESUME: legal_op = es & ~ws;
            `OP_WR_RESUME:  legal_op = ws;
            `OP_SET_LOCK,
            `OP_CLR_LOCK:   legal_op = ~es & ~ws;
            `OP_CLR_STATUS: legal_op = ~ws;
            `OP_NONE:       legal_op = 1'b0;
            default:        legal_op = 1'b1;
         endcase
      end
   endfunction

   flash_bus_cycle u_cycle (
      .clk    (I_CLK_SYS),
      .reset  (I_RESET),
      .start  (bc_start_r),
      .write  (bc_write_r),
      .wdata  (bc_wdata_r),
      .din    (I_FL_DQ),
      .we_n   (O_FL_WE_N),
      .oe_n   (O_FL_OE_N),
      .ce_n   (O_FL_CE_N),
      .dq_oe  (O_FL_DQ_OE),
      .dq_out (O_FL_DQ),
      .rdata  (bc_rdata),
      .done   (bc_done)
   );

   // Register slave: ack one cycle after the request, dropped the next cycle
   always @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
         addr_r   <= 21'h000000;
      end else begin
         O_WB_ACK <= wb_req;
         if (wb_req & I_WB_WE & (I_WB_ADR == `REG_ADDR)) begin
            if (I_WB_SEL[0]) addr_r[7:0]   <= I_WB_DAT[7:0];
            if (I_WB_SEL[1]) addr_r[15:8]  <= I_WB_DAT[15:8];
            if (I_WB_SEL[2]) addr_r[20:16] <= I_WB_DAT[20:16];
         end
         if (wb_req & ~I_WB_WE) begin
            if (I_WB_ADR == `REG_CTRL)
               O_WB_DAT <= {28'h0000000, op_r};
            else if (I_WB_ADR == `REG_ADDR)
               O_WB_DAT <= {11'h000, addr_r};
            else if (I_WB_ADR == `REG_STAT)
               O_WB_DAT <= {25'h0000000, ~I_READY_BUSY_N, lock_unknown_r, wr_susp_r,
                            ers_susp_r, susp_ok_r, err_r, busy_r};
            else if (I_WB_ADR == `REG_FSR)
               O_WB_DAT <= {24'h000000, fsr_r};
            else
               O_WB_DAT <= 32'h00000000;
         end
      end
   end

   // Command sequencer
   always @(posedge I_CLK_SYS) begin
      bc_start_r <= 1'b0;
      if (I_RESET) begin
         state_r        <= S_IDLE;
         op_r           <= `OP_NONE;
         busy_r         <= 1'b0;
         err_r          <= 1'b0;
         susp_ok_r      <= 1'b0;
         ers_susp_r     <= 1'b0;
         wr_susp_r      <= 1'b0;
         lock_unknown_r <= 1'b0;
         fsr_r          <= 8'h00;
         bc_write_r     <= 1'b0;
         bc_wdata_r     <= 16'h0000;
         O_FL_ADDR      <= 21'h000000;
         O_FL_RESET_N   <= 1'b0;
      end else begin
         O_FL_RESET_N <= 1'b1;
         case (state_r)
            S_IDLE: if (go) begin
               op_r <= I_WB_DAT[3:0];
               if (legal_op(I_WB_DAT[3:0], ers_susp_r, wr_susp_r)) begin
                  busy_r     <= 1'b1;
                  err_r      <= 1'b0;
                  susp_ok_r  <= 1'b0;
                  O_FL_ADDR  <= addr_r;
                  bc_write_r <= 1'b1;
                  bc_wdata_r <= first_cmd(I_WB_DAT[3:0]);
                  bc_start_r <= 1'b1;
                  state_r    <= S_CMD1;
               end else begin
                  err_r <= 1'b1;
               end
            end
            S_CMD1: if (bc_done) begin
               bc_start_r <= 1'b1;
               bc_write_r <= 1'b1;
               state_r    <= S_CMD2;
               if (op_r == `OP_SET_LOCK)
                  bc_wdata_r <= `CMD_SET_CONFIRM;
               else if (op_r == `OP_CLR_LOCK)
                  bc_wdata_r <= `CMD_CLR_CONFIRM;
               else if (op_r == `OP_READ_ARRAY) begin
                  bc_start_r <= 1'b0;
                  busy_r     <= 1'b0;
                  state_r    <= S_IDLE;
               end else
                  bc_wdata_r <= `CMD_READ_STAT;
            end
            S_CMD2: if (bc_done) begin
               // Card now answers every read with status
               state_r <= S_POLL;
            end
            S_POLL: begin
               bc_start_r <= 1'b1;
               bc_write_r <= 1'b0;
               state_r    <= S_RDST;
            end
            S_RDST: if (bc_done) begin
               fsr_r <= bc_rdata[7:0];
               // Other flags mean nothing until the machine is ready
               if (!bc_rdata[`SR_READY] || !I_READY_BUSY_N) begin
                  if (op_r == `OP_ERS_RESUME || op_r == `OP_WR_RESUME ||
                      op_r == `OP_READ_STATUS || op_r == `OP_CLR_STATUS)
                     state_r <= S_DONE;
                  else
                     state_r <= S_POLL;
               end else
                  state_r <= S_DONE;
            end
            default: begin
               busy_r  <= 1'b0;
               state_r <= S_IDLE;
               case (op_r)
                  `OP_ERS_SUSP: begin
                     // Erase may have finished before it could halt
                     ers_susp_r <= fsr_r[`SR_ERS_SUSP];
                     susp_ok_r  <= fsr_r[`SR_ERS_SUSP];
                  end
                  `OP_WR_SUSP: begin
                     wr_susp_r <= fsr_r[`SR_WR_SUSP];
                     susp_ok_r <= fsr_r[`SR_WR_SUSP];
                  end
                  `OP_ERS_RESUME: ers_susp_r <= 1'b0;
                  `OP_WR_RESUME:  wr_susp_r  <= 1'b0;
                  `OP_SET_LOCK:
                     err_r <= fsr_r[`SR_WR_ERR] | fsr_r[`SR_ERS_ERR];
                  `OP_CLR_LOCK: begin
                     err_r          <= fsr_r[`SR_ERS_ERR];
                     lock_unknown_r <= fsr_r[`SR_ERS_ERR];
                  end
                  default: ;
               endcase
               if (op_r == `OP_CLR_LOCK && !fsr_r[`SR_ERS_ERR])
                  lock_unknown_r <= 1'b0;
               // Failed lock operation: clear card status on the next CLR_STATUS op
            end
         endcase
         if (state_r == S_CMD1 && op_r == `OP_CLR_LOCK)
            lock_unknown_r <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [pkg/flash_seq_map.vh]
// Constants for the flash suspend and lock sequencer host controller
// What this block does
// - Host reads status after erase suspend; erase may already have finished.
// - Set lock-bit is setup write then confirm write within the block.
// - Host checks write/set-lock error after set lock-bit, flags it in STAT; a CLR_STATUS op clears.
// - Clear lock-bits is setup then confirm; all lock-bits cleared.
// - Host checks erase/clear-lock error after clear, flags it in STAT; a CLR_STATUS op clears.
// - Aborted clear leaves lock-bits undefined; host flags them unknown in STAT after a failed clear until one succeeds; I_RESET clears the flag.
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH
// Controller registers, word aligned byte addresses
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_STAT        8'h08
`define REG_FSR         8'h0c
// Operation codes written to CTRL[3:0]; CTRL bit 4 starts
`define OP_NONE         4'h0
`define OP_ERS_SUSP     4'h1
`define OP_ERS_RESUME   4'h2
`define OP_WR_SUSP      4'h3
`define OP_WR_RESUME    4'h4
`define OP_SET_LOCK     4'h5
`define OP_CLR_LOCK     4'h6
`define OP_CLR_STATUS   4'h7
`define OP_READ_STATUS  4'h8
`define OP_READ_ARRAY   4'h9
`define CTRL_GO_BIT     4
// Flash command words
`define CMD_READ_ARRAY  16'hffff
`define CMD_READ_STAT   16'h7070
`define CMD_CLR_STAT    16'h5050
`define CMD_SUSPEND     16'hb0b0
`define CMD_RESUME      16'hd0d0
`define CMD_LOCK_SETUP  16'h6060
`define CMD_SET_CONFIRM 16'h0101
`define CMD_CLR_CONFIRM 16'hd0d0
// Flash status bit positions
`define SR_READY        7
`define SR_ERS_SUSP     6
`define SR_ERS_ERR      5
`define SR_WR_ERR       4
`define SR_WR_SUSP      2
// Bus cycle timing: strobe low time in system clocks
`define T_STROBE_NS     100
`define T_STROBE_CYC    (((`T_STROBE_NS) * 10 + 999) / 1000)
`endif

// [rtl/flash_bus_cycle.v]
// One asynchronous flash bus write or read cycle with strobe timing
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_map.vh"
module flash_bus_cycle (
   input  wire        clk,          // System clock
   input  wire        reset,        // Synchronous reset
   input  wire        start,        // Start one cycle, pulse
   input  wire        write,        // 1 write, 0 read
   input  wire [15:0] wdata,        // Data to write
   input  wire [15:0] din,          // Data from card
   output reg         we_n,         // Write strobe
   output reg         oe_n,         // Output enable
   output reg         ce_n,         // Chip enable
   output reg         dq_oe,        // Drive data pins
   output reg  [15:0] dq_out,       // Data to card
   output reg  [15:0] rdata,        // Captured read data
   output reg         done          // Cycle finished, pulse
);
   localparam [1:0] S_IDLE = 2'd0, S_STRB = 2'd1, S_REL = 2'd2;
   reg [1:0] state_r;
   reg [3:0] cnt_r;
   always @(posedge clk) begin
      done <= 1'b0;
      if (reset) begin
         state_r <= S_IDLE;
         cnt_r   <= 4'h0;
         we_n    <= 1'b1;
         oe_n    <= 1'b1;
         ce_n    <= 1'b1;
         dq_oe   <= 1'b0;
         dq_out  <= 16'h0000;
         rdata   <= 16'h0000;
      end else begin
         case (state_r)
            S_IDLE: if (start) begin
               ce_n    <= 1'b0;
               we_n    <= ~write;
               oe_n    <= write;
               dq_oe   <= write;
               dq_out  <= wdata;
               cnt_r   <= 4'h0;
               state_r <= S_STRB;
            end
            S_STRB: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r >= `T_STROBE_CYC) begin
                  // Status latches on each strobe, so strobes always rise between reads
                  rdata   <= din;
                  we_n    <= 1'b1;
                  oe_n    <= 1'b1;
                  ce_n    <= 1'b1;
                  state_r <= S_REL;
               end
            end
            default: begin
               // Hold data one cycle past the rising write strobe
               dq_oe   <= 1'b0;
               done    <= 1'b1;
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [verification/flash_seq_props.sv]
// Port checker for the flash suspend and lock host controller
`timescale 1ns/10ps
`default_nettype none
module flash_seq_props (
   input wire logic        I_CLK_SYS,  // Clock
   input wire logic        I_RESET,    // Reset
   input wire logic        I_WB_CYC,   // Bus cycle
   input wire logic        I_WB_STB,   // Bus strobe
   input wire logic        O_WB_ACK,   // Bus ack
   input wire logic [15:0] O_FL_DQ,    // Card data
   input wire logic        O_FL_DQ_OE, // Card data drive
   input wire logic        O_FL_CE_N,  // Card select
   input wire logic        O_FL_OE_N,  // Card read strobe
   input wire logic        O_FL_WE_N   // Card write strobe
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("ack late");
   a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
   a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   a_we_width: assert property ($fell(O_FL_WE_N) |=> !O_FL_WE_N ##1 O_FL_WE_N)
      else $error("write strobe width");
   a_oe_width: assert property ($fell(O_FL_OE_N) |=> !O_FL_OE_N ##1 O_FL_OE_N)
      else $error("read strobe width");
   a_strobe_sel: assert property (!O_FL_WE_N || !O_FL_OE_N |-> !O_FL_CE_N && (O_FL_WE_N || O_FL_OE_N))
      else $error("strobe without select");
   a_no_fight: assert property (!O_FL_OE_N |-> !O_FL_DQ_OE) else $error("drive during read");
   a_data_hold:
      assert property ($rose(O_FL_WE_N) |-> (O_FL_DQ_OE && $stable(O_FL_DQ)) ##1 !O_FL_DQ_OE)
      else $error("write data not held");
   a_lock_confirm:
      assert property ($rose(O_FL_WE_N) && O_FL_DQ == 16'h6060 |->
         ##3 ($fell(O_FL_WE_N) && (O_FL_DQ == 16'h0101 || O_FL_DQ == 16'hd0d0)))
      else $error("lock setup without confirm");
   a_susp_poll:
      assert property ($rose(O_FL_WE_N) && O_FL_DQ == 16'hb0b0 |->
         ##[2:4] ($fell(O_FL_WE_N) && O_FL_DQ == 16'h7070))
      else $error("suspend without status read");
   cover property ($fell(O_FL_WE_N) && O_FL_DQ == 16'h0101);
   cover property ($fell(O_FL_WE_N) && O_FL_DQ == 16'hd0d0);
   cover property ($fell(O_FL_WE_N) && O_FL_DQ == 16'hb0b0);
endmodule
`default_nettype wire

// [verification/flash_card_model.sv]
// Behavioural flash card answering suspend, resume and lock-bit commands
`timescale 1ns/10ps
`default_nettype none
module flash_card_model (
   input  wire logic        clk,   // Card time base
   input  wire logic        rst_n, // Card reset
   input  wire logic [20:0] addr,  // Word address
   input  wire logic [15:0] din,   // Data from host
   input  wire logic        ce_n,  // Select
   input  wire logic        oe_n,  // Read strobe
   input  wire logic        we_n,  // Write strobe
   input  wire logic [1:0]  kick,  // Start 1 erase, 2 write
   input  wire logic        bad,   // Fail lock operations
   output logic      [15:0] dout,  // Data to host
   output logic             rdy    // High when ready
);
   logic [31:0] locks = 32'h0;
   logic [15:0] last = 16'h0;
   logic        we_q, ce_q, smode, setup, es, ws, e4, e5, rpend;
   int          run, cnt, halt;
   // Protect bit carries noise while busy, so a host leaning on flags then is caught
   wire  [7:0]  sr = {run == 0, es, e5, e4, 1'b0, ws, run != 0 && cnt[0], 1'b0};
   assign rdy = run == 0;
   // Released bus shows the inverse of the last read so stale data never matches
   assign dout = (!ce_n && !oe_n) ? (smode ? {sr, sr} : ~addr[15:0]) : ~last;
   always @(posedge clk) begin
      we_q <= we_n;
      ce_q <= ce_n;
      if (!ce_n && !oe_n) last <= dout;
      if (!rst_n) begin
         if (run == 4) locks <= locks ^ 32'h5a5a_5a5a;
         run <= 0;
         halt <= 0;
         {setup, es, ws, e4, e5, rpend, smode} <= 7'h0;
      end else begin
         if (kick != 2'h0) begin
            run <= kick;
            cnt <= 300;
         end else if (halt > 1) halt <= halt - 1;
         else if (halt == 1) begin
            halt <= 0;
            es <= es || run == 1;
            ws <= run == 2;
            run <= 0;
         end else if (run != 0 && cnt > 1) cnt <= cnt - 1;
         else if (run != 0) begin
            run <= rpend ? 1 : 0;
            es <= es && !rpend;
            rpend <= 1'b0;
            cnt <= 300;
         end
         if (we_n && !we_q && !ce_q) begin
            if (setup) begin
               setup <= 1'b0;
               if (din == 16'h0101 || din == 16'hd0d0) begin
                  if (din == 16'h0101 && !bad) locks[addr[20:16]] <= 1'b1;
                  if (din == 16'hd0d0 && !bad) locks <= 32'h0;
                  e4 <= bad && din == 16'h0101;
                  e5 <= bad && din == 16'hd0d0;
                  run <= din == 16'h0101 ? 3 : 4;
                  cnt <= 10;
               end else begin
                  e4 <= 1'b1;
                  e5 <= 1'b1;
               end
            end else if (!ws || din == 16'hffff || din == 16'h7070 || din == 16'hd0d0) begin
               smode <= din != 16'hffff;
               case (din)
                  16'h6060: setup <= run == 0 && !es;
                  16'h5050: if (run == 0 && !es) {e4, e5} <= 2'b00;
                  16'hb0b0: if (run == 1 || run == 2) halt <= 3;
                  16'hd0d0: if (ws) begin
                     ws <= 1'b0;
                     run <= 2;
                  end else if (es && run == 2) rpend <= 1'b1;
                  else if (es) begin
                     es <= 1'b0;
                     run <= 1;
                  end
                  default: ;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the flash suspend and lock host controller
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_map.vh"
module tb_top;
   logic        clk, rst, we, cyc, stb, ack, ce_n, oe_n, we_n, frst_n, dq_oe, rdy, bad;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [1:0]  kick;
   logic [31:0] wd, rd, st, a, m_locks;
   logic [20:0] fa;
   logic [15:0] dq_h, dq_c;
   int          num_errors, samples_checked, seed, k, n;
   flash_seq_host u_dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_WB_ADR(adr), .I_WB_DAT(wd),
      .I_WB_SEL(sel), .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb), .O_WB_DAT(rd),
      .O_WB_ACK(ack), .O_FL_ADDR(fa), .O_FL_DQ(dq_h), .O_FL_DQ_OE(dq_oe), .I_FL_DQ(dq_c),
      .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .O_FL_RESET_N(frst_n),
      .I_READY_BUSY_N(rdy));
   flash_card_model u_card (.clk(clk), .rst_n(frst_n), .addr(fa), .din(dq_h), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .kick(kick), .bad(bad), .dout(dq_c), .rdy(rdy));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
      int c;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wd <= d;
      c = 0;
      do begin @(posedge clk); c++; end while (ack !== 1'b1 && c < 20);
      if (c >= 20) begin num_errors++; finish_test; end
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Poll busy so the card sequence is known to be over before checking
   task automatic op(input logic [3:0] c, input logic [20:0] ad);
      int p;
      wb(1'b1, `REG_ADDR, {11'h0, ad}, st);
      wb(1'b1, `REG_CTRL, {27'h0, 1'b1, c}, st);
      p = 0;
      do begin wb(1'b0, `REG_STAT, 32'h0, st); p++; end while (st[0] !== 1'b0 && p < 500);
      if (p >= 500) begin num_errors++; finish_test; end
   endtask
   task automatic cs(input int cb, input int unk, input int ws, input int es, input int er);
      check(st & 32'h7b, 32'(cb * 64 + unk * 32 + ws * 16 + es * 8 + er * 2));
   endtask
   task automatic fsr(input logic [31:0] exp);
      wb(1'b0, `REG_FSR, 32'h0, a);
      check(a & 32'hff, exp);
   endtask
   initial begin
      seed = 1185;
      num_errors = 0;
      samples_checked = 0;
      m_locks = 32'h0;
      {rst, cyc, stb, we, bad, adr, wd, sel, kick} = {5'h10, 8'h00, 32'h0, 4'hf, 2'h0};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, 8'h10, 32'h0, a);
      check(a, 32'h0);
      check({31'h0, frst_n}, 32'h1);
      op(`OP_ERS_SUSP, 21'h0);
      check({31'h0, st[2]}, 32'h0);
      cs(0, 0, 0, 0, 0);
      for (k = 1; k <= 2; k++) begin
         kick <= k[1:0];
         @(posedge clk);
         kick <= 2'h0;
         op(k == 1 ? `OP_ERS_SUSP : `OP_WR_SUSP, 21'h0);
         check({31'h0, st[2]}, 32'h1);
         cs(0, 0, k - 1, 2 - k, 0);
         fsr(k == 1 ? 32'hc0 : 32'h84);
         op(k == 1 ? `OP_ERS_RESUME : `OP_WR_RESUME, 21'h0);
         cs(1, 0, 0, 0, 0);
         for (n = 0; n < 1000 && rdy !== 1'b1; n++) @(posedge clk);
         if (n >= 1000) begin num_errors++; finish_test; end
      end
      for (k = 0; k < 3; k++) begin
         a = $random(seed);
         op(`OP_SET_LOCK, a[20:0]);
         m_locks[a[20:16]] = 1'b1;
         check({11'h0, fa}, {11'h0, a[20:0]});
         check(u_card.locks, m_locks);
         cs(0, 0, 0, 0, 0);
         fsr(32'h80);
      end
      bad <= 1'b1;
      op(`OP_SET_LOCK, 21'h1f0000);
      cs(0, 0, 0, 0, 1);
      check(u_card.locks, m_locks);
      bad <= 1'b0;
      op(`OP_CLR_STATUS, 21'h0);
      a = $random(seed);
      op(`OP_CLR_LOCK, a[20:0]);
      m_locks = 32'h0;
      check(u_card.locks, m_locks);
      cs(0, 0, 0, 0, 0);
      fsr(32'h80);
      check({31'h0, u_card.smode}, 32'h1);
      op(`OP_READ_ARRAY, 21'h0);
      check({31'h0, u_card.smode}, 32'h0);
      op(`OP_READ_STATUS, 21'h0);
      check({31'h0, u_card.smode}, 32'h1);
      fsr(32'h80);
      // Resume with nothing suspended is refused without touching the card
      op(`OP_WR_RESUME, 21'h0);
      check({31'h0, st[1]}, 32'h1);
      cs(0, 0, 0, 0, 1);
      finish_test;
   end
endmodule
bind flash_seq_host flash_seq_props u_props (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_FL_DQ(O_FL_DQ),
   .O_FL_DQ_OE(O_FL_DQ_OE), .O_FL_CE_N(O_FL_CE_N), .O_FL_OE_N(O_FL_OE_N),
   .O_FL_WE_N(O_FL_WE_N));
`default_nettype wire
